// ==== hdl/dod_config_regs.sv ====
// Purpose: DAC power, headphone common-pin, protection and routing settings
// Assumes: Control-bus front end issues one-cycle read and write strobes
// Notes:   Reserved codes in mode fields are refused; the field keeps its value
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Bit 7 powers the left DAC
// - Bit 6 powers the right DAC
// - Left common pin mode, reserved code refused
// - Right common pin mode, codes 101-111 refused
// - Protection enable covers all high-power drivers
// - Mode bit: limit current or auto power-down
// - Top bits set output common-mode level
// - Left aux bypass source select
// - Right aux bypass source select
// - Soft-step every sample, every two, or off
// - Left DAC path routing, reserved refused
// - Right DAC path routing, reserved refused
// - Volume link: left follows right or reverse
module dod_config_regs #(
  parameter int NDRV = dod_pkg::NUM_DRV
) (
  // Clock, reset, clock enable
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  // Register port
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  output logic                 reg_rvalid,
  // Analog status and sample timing
  input  wire logic [NDRV-1:0] short_raw,
  input  wire logic            fs_tick,
  // DAC power
  output logic                 left_dac_power_up,
  output logic                 right_dac_power_up,
  // Headphone common pins
  output logic      [1:0]      left_phone_common_pin_mode,
  output logic      [2:0]      right_phone_common_pin_mode,
  // Short protection
  output logic                 protect_en,
  output logic                 current_limit_en,
  output logic      [NDRV-1:0] driver_shutdown,
  // Output stage
  output logic      [1:0]      common_mode_level,
  output logic      [1:0]      left_aux_input_pair_bypass,
  output logic      [1:0]      right_aux_input_pair_bypass,
  output logic                 vol_step,
  output logic                 vol_step_direct,
  // Routing and volume link
  output logic      [1:0]      left_converter_route,
  output logic      [1:0]      right_converter_route,
  output logic                 left_vol_follows_right,
  output logic                 right_vol_follows_left
);

  // Field registers
  logic            ldac_reg;
  logic            rdac_reg;
  logic [1:0]      lcom_reg;
  logic [2:0]      rcom_reg;
  logic            prot_reg;
  logic            auto_reg;
  logic [1:0]      cm_reg;
  logic [1:0]      lbyp_reg;
  logic [1:0]      rbyp_reg;
  logic [1:0]      ss_reg;
  logic [1:0]      lrt_reg;
  logic [1:0]      rrt_reg;
  logic [1:0]      link_reg;
  // Derived output registers
  logic            limit_reg;
  logic            half_reg;
  logic            step_reg;
  logic            direct_reg;
  logic            lfol_reg;
  logic            rfol_reg;
  logic [7:0]      rdata_reg;
  logic            rvalid_reg;
  logic [NDRV-1:0] shut;

  // Address decode
  wire        wr_pwr = reg_wr && (reg_addr == dod_pkg::ADDR_PWR);
  wire        wr_hpd = reg_wr && (reg_addr == dod_pkg::ADDR_HPD);
  wire        wr_ost = reg_wr && (reg_addr == dod_pkg::ADDR_OST);
  wire        wr_sw  = reg_wr && (reg_addr == dod_pkg::ADDR_SW);

  // Incoming fields
  wire [1:0]  w_lcom = reg_wdata[dod_pkg::PWR_LCOM_LSB +: 2];
  wire [2:0]  w_rcom = reg_wdata[dod_pkg::HPD_RCOM_LSB +: 3];
  wire [1:0]  w_ss   = reg_wdata[dod_pkg::OST_SS_LSB +: 2];
  wire [1:0]  w_lrt  = reg_wdata[dod_pkg::SW_LRT_LSB +: 2];
  wire [1:0]  w_rrt  = reg_wdata[dod_pkg::SW_RRT_LSB +: 2];
  wire        ok_lcom = dod_pkg::code2_ok(w_lcom);
  wire        ok_rcom = w_rcom < dod_pkg::RCOM_RSV_LO;
  wire        ok_ss   = dod_pkg::code2_ok(w_ss);
  wire        ok_lrt  = dod_pkg::code2_ok(w_lrt);
  wire        ok_rrt  = dod_pkg::code2_ok(w_rrt);

  // Read images: reserved bits and the reserved register read zero
  wire [7:0]  img_pwr = {ldac_reg, rdac_reg, lcom_reg, 4'h0};
  wire [7:0]  img_hpd = {2'h0, rcom_reg, prot_reg, auto_reg, 1'h0};
  wire [7:0]  img_ost = {cm_reg, lbyp_reg, rbyp_reg, ss_reg};
  wire [7:0]  img_sw  = {lrt_reg, rrt_reg, 2'h0, link_reg};
  wire [7:0]  rd_mux  = (reg_addr == dod_pkg::ADDR_PWR) ? img_pwr :
                        (reg_addr == dod_pkg::ADDR_HPD) ? img_hpd :
                        (reg_addr == dod_pkg::ADDR_RSV) ? dod_pkg::RST_RSV :
                        (reg_addr == dod_pkg::ADDR_OST) ? img_ost :
                        (reg_addr == dod_pkg::ADDR_SW)  ? img_sw  : 8'h00;

  // Soft-step pacing
  wire        step_next = fs_tick && ((ss_reg == dod_pkg::SS_ONE) ||
                          ((ss_reg == dod_pkg::SS_TWO) && half_reg));
  wire        auto_off  = prot_reg && auto_reg;

  // Power and common-pin fields
  always_ff @(posedge clk) begin
    if (rst) begin
      ldac_reg <= dod_pkg::RST_PWR[dod_pkg::PWR_LDAC_BIT];
      rdac_reg <= dod_pkg::RST_PWR[dod_pkg::PWR_RDAC_BIT];
      lcom_reg <= dod_pkg::RST_PWR[dod_pkg::PWR_LCOM_LSB +: 2];
      rcom_reg <= dod_pkg::RST_HPD[dod_pkg::HPD_RCOM_LSB +: 3];
      prot_reg <= dod_pkg::RST_HPD[dod_pkg::HPD_PROT_BIT];
      auto_reg <= dod_pkg::RST_HPD[dod_pkg::HPD_AUTO_BIT];
    end else if (ce) begin
      if (wr_pwr) begin
        ldac_reg <= reg_wdata[dod_pkg::PWR_LDAC_BIT];
        rdac_reg <= reg_wdata[dod_pkg::PWR_RDAC_BIT];
      end
      if (wr_pwr && ok_lcom) begin
        lcom_reg <= w_lcom;
      end
      if (wr_hpd && ok_rcom) begin
        rcom_reg <= w_rcom;
      end
      if (wr_hpd) begin
        prot_reg <= reg_wdata[dod_pkg::HPD_PROT_BIT];
        auto_reg <= reg_wdata[dod_pkg::HPD_AUTO_BIT];
      end
    end
  end

  // Output stage fields
  always_ff @(posedge clk) begin
    if (rst) begin
      cm_reg   <= dod_pkg::RST_OST[dod_pkg::OST_CM_LSB +: 2];
      lbyp_reg <= dod_pkg::RST_OST[dod_pkg::OST_LBYP_LSB +: 2];
      rbyp_reg <= dod_pkg::RST_OST[dod_pkg::OST_RBYP_LSB +: 2];
      ss_reg   <= dod_pkg::RST_OST[dod_pkg::OST_SS_LSB +: 2];
    end else if (ce && wr_ost) begin
      cm_reg   <= reg_wdata[dod_pkg::OST_CM_LSB +: 2];
      lbyp_reg <= reg_wdata[dod_pkg::OST_LBYP_LSB +: 2];
      rbyp_reg <= reg_wdata[dod_pkg::OST_RBYP_LSB +: 2];
      if (ok_ss) begin
        ss_reg <= w_ss;
      end
    end
  end

  // Routing and volume link fields
  always_ff @(posedge clk) begin
    if (rst) begin
      lrt_reg  <= dod_pkg::RST_SW[dod_pkg::SW_LRT_LSB +: 2];
      rrt_reg  <= dod_pkg::RST_SW[dod_pkg::SW_RRT_LSB +: 2];
      link_reg <= dod_pkg::RST_SW[dod_pkg::SW_LINK_LSB +: 2];
    end else if (ce && wr_sw) begin
      if (ok_lrt) begin
        lrt_reg <= w_lrt;
      end
      if (ok_rrt) begin
        rrt_reg <= w_rrt;
      end
      link_reg <= reg_wdata[dod_pkg::SW_LINK_LSB +: 2];
    end
  end

  // Derived controls, registered so every output leaves a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_reg  <= 1'b0;
      half_reg   <= 1'b0;
      step_reg   <= 1'b0;
      direct_reg <= 1'b0;
      lfol_reg   <= 1'b0;
      rfol_reg   <= 1'b0;
    end else if (ce) begin
      limit_reg  <= prot_reg && !auto_reg;
      half_reg   <= fs_tick ? !half_reg : half_reg;
      step_reg   <= step_next;
      direct_reg <= ss_reg == dod_pkg::SS_OFF;
      lfol_reg   <= link_reg == dod_pkg::LINK_L_FOLLOWS_R;
      rfol_reg   <= link_reg == dod_pkg::LINK_R_FOLLOWS_L;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg  <= reg_rd ? rd_mux : 8'h00;
      rvalid_reg <= reg_rd;
    end
  end

  // Synchroniser and latched automatic shutdown per driver
  dod_short_guard #(
    .N (NDRV)
  ) u_guard (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .auto_off  (auto_off),
    .short_raw (short_raw),
    .shutdown  (shut)
  );

  assign reg_rdata                   = rdata_reg;
  assign reg_rvalid                  = rvalid_reg;
  assign left_dac_power_up           = ldac_reg;
  assign right_dac_power_up          = rdac_reg;
  assign left_phone_common_pin_mode  = lcom_reg;
  assign right_phone_common_pin_mode = rcom_reg;
  assign protect_en                  = prot_reg;
  assign current_limit_en            = limit_reg;
  assign driver_shutdown             = shut;
  assign common_mode_level           = cm_reg;
  assign left_aux_input_pair_bypass  = lbyp_reg;
  assign right_aux_input_pair_bypass = rbyp_reg;
  assign vol_step                    = step_reg;
  assign vol_step_direct             = direct_reg;
  assign left_converter_route        = lrt_reg;
  assign right_converter_route       = rrt_reg;
  assign left_vol_follows_right      = lfol_reg;
  assign right_vol_follows_left      = rfol_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_LDAC_WRITE: assert property (
    ce && wr_pwr |=> left_dac_power_up == $past(reg_wdata[7]))
    else $error("left DAC power does not follow write");

  AST_RDAC_WRITE: assert property (
    ce && wr_pwr |=> right_dac_power_up == $past(reg_wdata[6]))
    else $error("right DAC power does not follow write");

  AST_LCOM_REFUSE: assert property (
    ce && wr_pwr && (reg_wdata[5:4] == 2'h3) |=> $stable(left_phone_common_pin_mode))
    else $error("left common pin took reserved code");

  AST_RCOM_RANGE: assert property (
    ce && wr_hpd && (reg_wdata[5:3] >= 3'h5) |=> $stable(right_phone_common_pin_mode))
    else $error("right common pin took reserved code");

  AST_PROT_ALL: assert property (
    ce && wr_hpd |=> protect_en == $past(reg_wdata[2]))
    else $error("protection enable does not follow write");

  AST_LIMIT_MODE: assert property (
    ce && prot_reg && !auto_reg |=> current_limit_en && (driver_shutdown == '0))
    else $error("current limit mode not applied");

  AST_RSV_READ: assert property (
    ce && reg_rd && (reg_addr == 8'h27) |=> reg_rvalid && (reg_rdata == 8'h00))
    else $error("reserved register did not read zero");

  AST_CM_LEVEL: assert property (
    ce && wr_ost |=> common_mode_level == $past(reg_wdata[7:6]))
    else $error("common-mode level not updated");

  AST_BYP_WRITE: assert property (
    ce && wr_ost |=>
      {left_aux_input_pair_bypass, right_aux_input_pair_bypass} == $past(reg_wdata[5:2]))
    else $error("aux bypass selects not updated");

  AST_SS_OFF: assert property (
    ce && (ss_reg == 2'h2) |=> !vol_step && vol_step_direct)
    else $error("soft step active while disabled");

  AST_SS_HALF: assert property (
    ce && fs_tick && (ss_reg == 2'h1) && !half_reg |=> !vol_step)
    else $error("half-rate soft step fired on odd tick");

  AST_LROUTE: assert property (
    ce && wr_sw && (reg_wdata[7:6] != 2'h3) |=> left_converter_route == $past(reg_wdata[7:6]))
    else $error("left route not updated");

  AST_RROUTE: assert property (
    ce && wr_sw && (reg_wdata[5:4] != 2'h3) |=> right_converter_route == $past(reg_wdata[5:4]))
    else $error("right route not updated");

  AST_LINK_EXCL: assert property (
    ce && (link_reg == 2'h3) |=> !left_vol_follows_right && !right_vol_follows_left)
    else $error("code 11 must keep volumes independent");

  AST_RD_ZERO: assert property (
    ce && reg_rd && (reg_addr == 8'h25) |=> reg_rvalid && (reg_rdata[3:0] == 4'h0))
    else $error("reserved bits did not read zero");

  COV_SHUTDOWN: cover property (auto_off ##1 driver_shutdown != '0);
  COV_HALF_STEP: cover property ((ss_reg == 2'h1) && vol_step);
  COV_READ_BACK: cover property (ce && wr_sw ##1 ce && reg_rd && (reg_addr == 8'h29));

endmodule

`default_nettype wire

// ==== hdl/dod_pkg.sv ====
// Purpose: Shared constants for the DAC output driver configuration bank
// Assumes: 8-bit register port with 8-bit page-local addresses
package dod_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PWR = 8'h25;
  localparam logic [7:0] ADDR_HPD = 8'h26;
  localparam logic [7:0] ADDR_RSV = 8'h27;
  localparam logic [7:0] ADDR_OST = 8'h28;
  localparam logic [7:0] ADDR_SW  = 8'h29;

  // Reset values
  localparam logic [7:0] RST_PWR = 8'h00;
  localparam logic [7:0] RST_HPD = 8'h00;
  localparam logic [7:0] RST_RSV = 8'h00;
  localparam logic [7:0] RST_OST = 8'h00;
  localparam logic [7:0] RST_SW  = 8'h00;

  // Field positions
  localparam int PWR_LDAC_BIT  = 7;
  localparam int PWR_RDAC_BIT  = 6;
  localparam int PWR_LCOM_LSB  = 4;
  localparam int HPD_RCOM_LSB  = 3;
  localparam int HPD_PROT_BIT  = 2;
  localparam int HPD_AUTO_BIT  = 1;
  localparam int OST_CM_LSB    = 6;
  localparam int OST_LBYP_LSB  = 4;
  localparam int OST_RBYP_LSB  = 2;
  localparam int OST_SS_LSB    = 0;
  localparam int SW_LRT_LSB    = 6;
  localparam int SW_RRT_LSB    = 4;
  localparam int SW_LINK_LSB   = 0;

  // Codes
  localparam logic [1:0] CODE2_RSV   = 2'h3;
  localparam logic [2:0] RCOM_RSV_LO = 3'h5;
  localparam logic [1:0] SS_ONE      = 2'h0;
  localparam logic [1:0] SS_TWO      = 2'h1;
  localparam logic [1:0] SS_OFF      = 2'h2;
  localparam logic [1:0] LINK_L_FOLLOWS_R = 2'h1;
  localparam logic [1:0] LINK_R_FOLLOWS_L = 2'h2;

  // Number of high-power drivers guarded by short protection
  localparam int NUM_DRV = 4;

  // Two-bit common-pin, soft-step and routing fields share one reserved code
  function automatic logic code2_ok(input logic [1:0] code);
    return code != CODE2_RSV;
  endfunction

endpackage

// ==== hdl/dod_short_guard.sv ====
// Purpose: Short-circuit detect synchroniser and automatic driver power-down
// Assumes: Short detect levels come from the analog drivers, asynchronous
// Notes:   A shutdown stays latched until auto power-down is turned off
`timescale 1ns/1ns
`default_nettype none

module dod_short_guard #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Control
  input  wire logic         auto_off,
  // Driver side
  input  wire logic [N-1:0] short_raw,
  output logic      [N-1:0] shutdown
);

  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [N-1:0] s3_reg;
  logic [N-1:0] det_reg;
  logic [N-1:0] shut_reg;
  logic [N-1:0] agree;
  logic [N-1:0] det_next;
  logic [N-1:0] shut_next;

  // A level counts only once the last two stages agree
  assign agree     = ~(s2_reg ^ s3_reg);
  assign det_next  = (agree & s3_reg) | (~agree & det_reg);
  assign shut_next = auto_off ? (shut_reg | det_reg) : '0;
  assign shutdown  = shut_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      det_reg  <= '0;
      shut_reg <= '0;
    end else if (ce) begin
      s1_reg   <= short_raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      det_reg  <= det_next;
      shut_reg <= shut_next;
    end
  end

endmodule

`default_nettype wire

// ==== tb/dod_config_regs_tb.sv ====
// Purpose: Self-checking bench for the DAC output driver config bank
// Assumes: Host model owns the register port; bench drives the rest
// Notes:   Field outputs are packed into register-shaped views for compares
`timescale 1ns/1ns
`default_nettype none

module dod_config_regs_tb;
  logic       clk = 1'b0;
  logic       rst;
  logic       ce;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [3:0] short_raw;
  logic       fs_tick;
  logic       l_pwr, r_pwr, prot, cle, vstep, vdir, lvfr, rvfl;
  logic [1:0] l_com, cm, lbyp, rbyp, lrt, rrt;
  logic [2:0] r_com;
  logic [3:0] shut;
  int         failures;
  int         checks;

  wire logic [7:0] pwr_v = {l_pwr, r_pwr, l_com, 4'h0};
  wire logic [7:0] hpd_v = {2'h0, r_com, prot, cle, 1'b0};
  wire logic [7:0] ost_v = {cm, lbyp, rbyp, vdir, 1'b0};
  wire logic [7:0] sw_v  = {lrt, rrt, 2'h0, lvfr, rvfl};

  always #2 clk = ~clk;

  dod_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  dod_config_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .short_raw(short_raw), .fs_tick(fs_tick),
    .left_dac_power_up(l_pwr), .right_dac_power_up(r_pwr),
    .left_phone_common_pin_mode(l_com), .right_phone_common_pin_mode(r_com),
    .protect_en(prot), .current_limit_en(cle), .driver_shutdown(shut),
    .common_mode_level(cm), .left_aux_input_pair_bypass(lbyp),
    .right_aux_input_pair_bypass(rbyp), .vol_step(vstep), .vol_step_direct(vdir),
    .left_converter_route(lrt), .right_converter_route(rrt),
    .left_vol_follows_right(lvfr), .right_vol_follows_left(rvfl));

  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, exp);
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Four sample ticks, count the soft-step pulses that follow them
  task automatic ticks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (4) begin
      @(posedge clk);
      fs_tick <= 1'b1;
      @(posedge clk);
      fs_tick <= 1'b0;
      #1;
      if (vstep === 1'b1) n = n + 8'h01;
    end
    chk(n, exp);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    logic [1:0] c;
    logic [1:0] e;
    logic [2:0] r;
    rst = 1'b1;
    ce = 1'b1;
    short_raw = 4'h0;
    fs_tick = 1'b0;
    failures = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_cy(1);
    for (int i = 0; i < 5; i++) rchk(8'h25 + i[7:0], 8'h00);
    rchk(8'h80, 8'h00);
    chk(pwr_v | hpd_v | ost_v | sw_v, 8'h00);
    host_u.wr(8'h25, 8'hEF);
    wait_cy(2);
    chk(pwr_v, 8'hE0);
    rchk(8'h25, 8'hE0);
    host_u.wr(8'h25, 8'h70);
    wait_cy(2);
    chk(pwr_v, 8'h60);
    for (int i = 0; i < 8; i++) begin
      r = (i < 5) ? i[2:0] : 3'h4;
      host_u.wr(8'h26, {2'h0, i[2:0], 3'h6});
      wait_cy(2);
      chk(hpd_v, {2'h0, r, 3'h4});
      rchk(8'h26, {2'h0, r, 3'h6});
    end
    // Short present with protection off must not power anything down
    host_u.wr(8'h26, 8'h22);
    @(posedge clk);
    short_raw <= 4'h5;
    wait_cy(8);
    chk({4'h0, shut}, 8'h00);
    host_u.wr(8'h26, 8'h26);
    wait_cy(8);
    chk({4'h0, shut}, 8'h05);
    @(posedge clk);
    short_raw <= 4'h0;
    wait_cy(8);
    chk({4'h0, shut}, 8'h05);
    host_u.wr(8'h26, 8'h24);
    wait_cy(2);
    chk({4'h0, shut}, 8'h00);
    chk(hpd_v, 8'h26);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      e = (c == 2'h3) ? 2'h2 : c;
      host_u.wr(8'h28, {c, c, c, c});
      wait_cy(2);
      chk(ost_v, {c, c, c, e == 2'h2, 1'b0});
      rchk(8'h28, {c, c, c, e});
    end
    host_u.wr(8'h28, 8'h00);
    ticks(8'h04);
    host_u.wr(8'h28, 8'h01);
    ticks(8'h02);
    host_u.wr(8'h28, 8'h02);
    ticks(8'h00);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      e = (c == 2'h3) ? 2'h2 : c;
      host_u.wr(8'h29, {c, c, 2'h3, c});
      wait_cy(2);
      chk(sw_v, {e, e, 2'h0, c == 2'h1, c == 2'h2});
      rchk(8'h29, {e, e, 2'h0, c});
    end
    rchk(8'h27, 8'h00);
    // A write strobe while the clock enable is low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    host_u.wr(8'h25, 8'hC0);
    @(posedge clk);
    ce <= 1'b1;
    rchk(8'h25, 8'h60);
    // A reset in mid-run must clear every field and derived control
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_cy(1);
    chk(pwr_v | hpd_v | ost_v | sw_v, 8'h00);
    rchk(8'h26, 8'h00);
    results();
  end
endmodule

`default_nettype wire

// ==== tb/dod_host_model.sv ====
// Purpose: Host model issuing register writes and reads to the config bank
// Assumes: One strobe per access, read answer one cycle after the strobe
// Notes:   Released address and data show the inverse so stale values never pass
`timescale 1ns/1ns
`default_nettype none

module dod_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Bits that may carry ones; reserved bits always go out as zero
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      8'h25:   keep_mask = 8'hF0;
      8'h26:   keep_mask = 8'h3E;
      8'h29:   keep_mask = 8'hF3;
      default: keep_mask = 8'hFF;
    endcase
  endfunction

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a != 8'h27) begin
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d & keep_mask(a);
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule

`default_nettype wire
